// [hdl/iha_pkg.sv]
// iha_pkg: constants and types of the two-wire host address launcher
package iha_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h18;
   localparam logic [7:0] TAC_OFS = 8'h24;
   localparam logic [7:0] DATA_OFS = 8'h28;
   // target address register: reset value and writable bits
   localparam logic [31:0] TAC_RST = 32'h0000_0000;
   localparam logic [31:0] TAC_MASK = 32'h00FF_E7FF;
   // target address register field positions
   localparam int TEN_BIT = 15;
   localparam int HS_BIT = 14;
   localparam int BYTE_COUNT_ENABLE_BIT = 13;
   localparam int LEN_LSB = 16;
   localparam int LEN_MSB = 23;
   localparam int TA_MSB = 10;
   // control and status bit positions
   localparam int CT_EN_BIT = 0;
   localparam int CT_FOUR_BIT = 1;
   localparam int ST_NACK_BIT = 1;
   // buffer entry layout: flags above the byte
   localparam int E_W = 12;
   localparam int E_MC = 11;
   localparam int E_START = 10;
   localparam int E_FAST = 9;
   localparam int E_RX = 8;
   // fixed bytes of the wire protocol
   localparam logic [7:0] MC_BYTE = 8'h08;
   localparam logic [4:0] TEN_PFX = 5'h1E;
   localparam logic [7:0] LEFT_RST = 8'h00;
   // half bit periods, in ns and in ref_clk cycles (rounded up)
   localparam int CLK_MHZ = 200;
   localparam int T_HALF_STD_NS = 1250;
   localparam int T_HALF_HS_NS = 150;
   localparam logic [8:0] HALF_STD_CYC = 9'((T_HALF_STD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] HALF_HS_CYC = 9'((T_HALF_HS_NS * CLK_MHZ + 999) / 1000);
   // byte producer states
   typedef enum logic [2:0] {
      PR_IDLE = 3'h0, PR_MC = 3'h1, PR_A1 = 3'h2, PR_A2 = 3'h3, PR_A3 = 3'h4, PR_DATA = 3'h5
   } iha_prod_t;
   // bit engine states
   typedef enum logic [3:0] {
      EN_IDLE = 4'h0, EN_START = 4'h1, EN_LOW = 4'h2, EN_HIGH = 4'h3, EN_WAIT = 4'h4,
      EN_RS1 = 4'h5, EN_RS2 = 4'h6, EN_STOP1 = 4'h7, EN_STOP2 = 4'h8, EN_STOP3 = 4'h9
   } iha_eng_t;
endpackage

// [hdl/iha_stream_if.sv]
// iha_stream_if: valid/ready carrier for buffer entries
`timescale 1ns/1ps
interface iha_stream_if #(parameter int W = 12) ();
   logic valid; // entry offered
   logic ready; // entry accepted
   logic [W-1:0] data; // entry content
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [hdl/iha_buf2.sv]
// iha_buf2: two-entry buffer between byte producer and bit engine
`timescale 1ns/1ps
module iha_buf2 import iha_pkg::*; #(
   parameter int W = 12
) (
   input wire logic clk, // ref clock
   input wire logic rst, // synchronous reset, high
   input wire logic flush, // drop all entries
   iha_stream_if.snk in_s, // filling side
   iha_stream_if.src out_s // draining side
);
   logic [W-1:0] mem_reg [2]; // entry storage
   logic wp_reg; // write index
   logic rp_reg; // read index
   logic [1:0] cnt_reg; // entries held
   wire push = in_s.valid & in_s.ready;
   wire pop = out_s.valid & out_s.ready;
   // full refuses, empty offers nothing
   assign in_s.ready = (cnt_reg != 2'h2);
   assign out_s.valid = (cnt_reg != 2'h0);
   assign out_s.data = mem_reg[rp_reg];
   // per-entry storage write
   for (genvar i = 0; i < 2; i++) begin : g_ent
      always_ff @(posedge clk) begin
         if (push && wp_reg == 1'(i)) begin
            mem_reg[i] <= in_s.data;
         end
      end
   end
   // pointers and fill level; flush wins over traffic
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         wp_reg <= wp_reg ^ push;
         rp_reg <= rp_reg ^ pop;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// [hdl/iha_top.sv]
// iha_top: two-wire host that launches a transfer from the target address register
`timescale 1ns/1ps
module iha_top import iha_pkg::*; (
   input wire logic ref_clk, // 200 MHz clock
   input wire logic srst, // synchronous reset, high
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic pad0_in, // data line level
   output logic pad0_out, // data line drive value
   output logic pad0_oe_n, // data line enable, low drives
   input wire logic pad1_in, // clock line level
   output logic pad1_out, // clock line drive value
   output logic pad1_oe_n, // clock line enable, low drives
   output logic pad2_out, // four-wire data out
   output logic pad2_oe_n, // four-wire data enable, low drives
   output logic pad3_out, // four-wire clock out
   output logic pad3_oe_n // four-wire clock enable, low drives
);
   ////////////////////////////////////////////////////////////////////////
   // registers and state
   logic ctrl_en_reg; // block enable
   logic four_reg; // four-wire pad use
   logic [31:0] tac_reg; // target address register
   logic nack_reg; // sticky: target refused a written byte
   logic rx_valid_reg; // received byte waiting
   logic [7:0] rx_reg; // last received byte
   logic [7:0] tx_reg; // next byte to send
   logic tx_full_reg; // tx_reg holds an unsent byte
   logic [7:0] left_reg; // data bytes still to queue
   iha_prod_t prod_reg; // producer state
   iha_prod_t prod_next;
   iha_eng_t eng_reg; // engine state
   iha_eng_t eng_next;
   logic [8:0] tm_reg, tm_next; // half-period timer
   logic [3:0] bit_reg, bit_next; // bit in byte, 8 is ack
   logic [E_W-1:0] cur_reg; // entry on the wire
   logic [7:0] shift_reg, shift_next; // sampled data bits
   logic sda_reg, sda_next; // data drive, 1 releases
   logic scl_reg, scl_next; // clock drive, 1 releases
   logic pop, nack_evt, rx_evt; // engine events
   iha_stream_if #(.W(E_W)) fill_s ();
   iha_stream_if #(.W(E_W)) drain_s ();

   ////////////////////////////////////////////////////////////////////////
   // register decode
   wire busy = (prod_reg != PR_IDLE) || (eng_reg != EN_IDLE);
   wire wr_tac = reg_wr && reg_addr == TAC_OFS;
   wire wr_ctrl = reg_wr && reg_addr == CTRL_OFS;
   wire wr_stat = reg_wr && reg_addr == STAT_OFS;
   wire wr_data = reg_wr && reg_addr == DATA_OFS;
   wire rd_data = reg_rd && reg_addr == DATA_OFS;
   // address register writes while busy are dropped so a running transfer keeps its fields
   wire tac_store = wr_tac && !busy;
   wire launch = tac_store && ctrl_en_reg;
   wire ten = tac_reg[TEN_BIT];
   wire hs = tac_reg[HS_BIT];
   wire byte_count_enable = tac_reg[BYTE_COUNT_ENABLE_BIT];
   wire [7:0] len = tac_reg[LEN_MSB:LEN_LSB];
   wire [TA_MSB:0] ta = tac_reg[TA_MSB:0];
   wire rd_dir = tac_reg[0];
   wire [31:0] stat_word = {16'h0000, left_reg, 4'h0, tx_full_reg, rx_valid_reg, nack_reg, busy};
   wire [31:0] rd_mux = (reg_addr == CTRL_OFS) ? {30'h0000_0000, four_reg, ctrl_en_reg} :
                        (reg_addr == STAT_OFS) ? stat_word :
                        (reg_addr == TAC_OFS) ? tac_reg :
                        (reg_addr == DATA_OFS) ? {24'h00_0000, rx_reg} : 32'h0000_0000;

   // software-side registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_en_reg <= 1'b0;
         four_reg <= 1'b0;
         tac_reg <= TAC_RST;
         tx_reg <= 8'h00;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_en_reg <= reg_wdata[CT_EN_BIT];
            four_reg <= reg_wdata[CT_FOUR_BIT];
         end
         if (tac_store) begin
            tac_reg <= reg_wdata & TAC_MASK;
         end
         if (wr_data) begin
            tx_reg <= reg_wdata[7:0];
         end
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000; // only in the cycle after
      end
   end

   // flags: a set wins over a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         nack_reg <= 1'b0;
         rx_valid_reg <= 1'b0;
         tx_full_reg <= 1'b0;
         rx_reg <= 8'h00;
      end else begin
         nack_reg <= nack_evt || (nack_reg && !(wr_stat && reg_wdata[ST_NACK_BIT]));
         rx_valid_reg <= rx_evt || (rx_valid_reg && !rd_data);
         tx_full_reg <= wr_data || (tx_full_reg && !(fill_s.ready && prod_reg == PR_DATA));
         if (rx_evt) begin
            rx_reg <= shift_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // byte producer: queues master code, address bytes and data slots
   wire [7:0] a1_byte = ten ? {TEN_PFX, ta[10:9], 1'b0} : ta[7:0];
   wire [7:0] p_byte = (prod_reg == PR_MC) ? MC_BYTE :
                       (prod_reg == PR_A1) ? a1_byte :
                       (prod_reg == PR_A2) ? ta[8:1] :
                       (prod_reg == PR_A3) ? {TEN_PFX, ta[10:9], 1'b1} : tx_reg;
   wire p_start = prod_reg == PR_MC || prod_reg == PR_A1 || prod_reg == PR_A3;
   wire p_fast = hs && prod_reg != PR_MC;
   wire p_rx = prod_reg == PR_DATA && rd_dir;
   // a write-direction data slot waits for software to fill tx_reg
   assign fill_s.valid = prod_reg != PR_IDLE && (prod_reg != PR_DATA || rd_dir || tx_full_reg);
   assign fill_s.data = {prod_reg == PR_MC, p_start, p_fast, p_rx, p_byte};
   wire push = fill_s.valid && fill_s.ready;
   // data phase only when the count is enabled and nonzero
   wire use_len = byte_count_enable && len != 8'h00;
   wire iha_prod_t after_addr = use_len ? PR_DATA : PR_IDLE;
   assign prod_next = (prod_reg == PR_MC) ? PR_A1 :
                      (prod_reg == PR_A1) ? (ten ? PR_A2 : after_addr) :
                      (prod_reg == PR_A2) ? (rd_dir ? PR_A3 : after_addr) :
                      (prod_reg == PR_A3) ? after_addr :
                      (left_reg == 8'h01) ? PR_IDLE : PR_DATA;

   // producer state; abort or disable stops queuing
   always_ff @(posedge ref_clk) begin
      if (srst || !ctrl_en_reg || nack_evt) begin
         prod_reg <= PR_IDLE;
         left_reg <= LEFT_RST;
      end else if (launch) begin
         prod_reg <= reg_wdata[HS_BIT] ? PR_MC : PR_A1;
         // status shows a remaining count only when a data phase will run
         left_reg <= reg_wdata[BYTE_COUNT_ENABLE_BIT] ? reg_wdata[LEN_MSB:LEN_LSB] : LEFT_RST;
      end else if (push) begin
         prod_reg <= prod_next;
         if (prod_reg == PR_DATA) begin
            left_reg <= left_reg - 8'h01;
         end
      end
   end

   // two-entry buffer lets the producer run ahead of the wire
   iha_buf2 #(.W(E_W)) u_buf (
      .clk(ref_clk),
      .rst(srst),
      .flush(nack_evt || !ctrl_en_reg),
      .in_s(fill_s),
      .out_s(drain_s)
   );
   assign drain_s.ready = pop;

   ////////////////////////////////////////////////////////////////////////
   // bit engine
   wire more = drain_s.valid || prod_reg != PR_IDLE;
   wire fast_sel = pop ? drain_s.data[E_FAST] : cur_reg[E_FAST];
   wire [8:0] half = fast_sel ? HALF_HS_CYC : HALF_STD_CYC;
   wire done = tm_reg == 9'h000;
   wire cur_rx = cur_reg[E_RX];
   // receiver acks every byte but the last
   wire rx_ack = (prod_reg == PR_IDLE && !drain_s.valid) ? 1'b1 : 1'b0;
   wire data_bit = cur_rx ? 1'b1 : cur_reg[~bit_reg[2:0]];
   wire bitval = (bit_reg == 4'h8) ? (cur_rx ? rx_ack : 1'b1) : data_bit;
   wire nack_seen = !cur_rx && pad0_in && !cur_reg[E_MC];

   // engine next state; clock changes on entry to each state but EN_IDLE, EN_START and EN_STOP3, data in EN_LOW, EN_RS1 and EN_STOP1 one cycle later
   always_comb begin
      eng_next = eng_reg;
      tm_next = done ? 9'h000 : tm_reg - 9'h001;
      bit_next = bit_reg;
      shift_next = shift_reg;
      sda_next = sda_reg;
      scl_next = scl_reg;
      pop = 1'b0;
      nack_evt = 1'b0;
      rx_evt = 1'b0;
      unique case (eng_reg)
         EN_IDLE: begin // bus free, wait for an entry
            if (drain_s.valid) begin
               pop = 1'b1;
               eng_next = EN_START;
               sda_next = 1'b0;
               tm_next = half;
            end
         end
         EN_START, EN_LOW: begin // start holds clock high; in low, clock is low and data follows one cycle later
            if (eng_reg == EN_LOW) begin
               sda_next = bitval;
            end
            scl_next = (eng_reg == EN_LOW) ? 1'b0 : scl_reg;
            if (done) begin
               eng_next = (eng_reg == EN_START) ? EN_LOW : EN_HIGH;
               scl_next = (eng_reg == EN_START) ? 1'b0 : 1'b1;
               bit_next = (eng_reg == EN_START) ? 4'h0 : bit_reg;
               tm_next = half;
            end
         end
         EN_HIGH, EN_WAIT: begin // sample, then next bit, entry or stop
            if (eng_reg == EN_HIGH && !pad1_in) begin
               tm_next = tm_reg; // target stretches the clock
            end else if (eng_reg == EN_HIGH && bit_reg != 4'h8 && done) begin
               shift_next = {shift_reg[6:0], pad0_in};
               bit_next = bit_reg + 4'h1;
               eng_next = EN_LOW;
               scl_next = 1'b0;
               tm_next = half;
            end else if (eng_reg == EN_WAIT || done) begin
               nack_evt = eng_reg == EN_HIGH && nack_seen;
               rx_evt = eng_reg == EN_HIGH && cur_rx;
               pop = !nack_evt && drain_s.valid;
               scl_next = 1'b0;
               tm_next = half;
               bit_next = 4'h0;
               if (pop) begin
                  eng_next = drain_s.data[E_START] ? EN_RS1 : EN_LOW;
               end else if (!nack_evt && more) begin
                  eng_next = EN_WAIT; // hold clock low for software
                  sda_next = 1'b1;
               end else begin
                  eng_next = EN_STOP1;
               end
            end
         end
         EN_RS1: begin // release data with clock low
            sda_next = 1'b1;
            if (done) begin
               eng_next = EN_RS2;
               scl_next = 1'b1;
               tm_next = half;
            end
         end
         EN_RS2: begin // both high, then repeated START
            if (done) begin
               eng_next = EN_START;
               sda_next = 1'b0;
               tm_next = half;
            end
         end
         EN_STOP1: begin // data low under low clock
            sda_next = 1'b0;
            if (done) begin
               eng_next = EN_STOP2;
               scl_next = 1'b1;
               tm_next = half;
            end
         end
         EN_STOP2: begin // data rises while clock high
            if (done) begin
               eng_next = EN_STOP3;
               sda_next = 1'b1;
               tm_next = half;
            end
         end
         EN_STOP3: begin // bus free time
            if (done) begin
               eng_next = EN_IDLE;
            end
         end
         default: begin
            eng_next = EN_IDLE;
         end
      endcase
   end

   // engine registers; disabling drops the bus at once
   always_ff @(posedge ref_clk) begin
      if (srst || !ctrl_en_reg) begin
         eng_reg <= EN_IDLE;
         tm_reg <= 9'h000;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         sda_reg <= 1'b1;
         scl_reg <= 1'b1;
         cur_reg <= '0;
      end else begin
         eng_reg <= eng_next;
         tm_reg <= tm_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         sda_reg <= sda_next;
         scl_reg <= scl_next;
         cur_reg <= pop ? drain_s.data : cur_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pads: open-drain in two-wire, push-pull outs in four-wire
   wire two_wire = ctrl_en_reg && !four_reg;
   assign pad0_out = 1'b0;
   assign pad1_out = 1'b0;
   assign pad0_oe_n = !(two_wire && !sda_reg);
   assign pad1_oe_n = !(two_wire && !scl_reg);
   assign pad2_out = sda_reg;
   assign pad3_out = scl_reg;
   assign pad2_oe_n = !(ctrl_en_reg && four_reg);
   assign pad3_oe_n = !(ctrl_en_reg && four_reg);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   AST_ONE_WRITE: assert property (launch |=> tac_reg == ($past(reg_wdata) & TAC_MASK))
      else $error("address write did not store all fields");
   AST_TEN_FIRST: assert property (push && prod_reg == PR_A1 && ten |->
      fill_s.data[7:3] == TEN_PFX && fill_s.data[E_START])
      else $error("wide address first byte wrong");
   AST_SEVEN: assert property (push && prod_reg == PR_A1 && !ten |->
      fill_s.data[7:0] == ta[7:0] ##1 prod_reg != PR_A2)
      else $error("narrow address sent as wide");
   AST_HS_FAST: assert property (launch && reg_wdata[HS_BIT] |=>
      prod_reg == PR_MC && !fill_s.data[E_FAST] ##[1:8] prod_reg == PR_A1 && fill_s.data[E_FAST])
      else $error("fast phase not entered after master code");
   AST_LEN_END: assert property (prod_reg == PR_DATA |-> left_reg != 8'h00 && use_len)
      else $error("data slot queued beyond byte count");
   AST_RELEASE: assert property (!ctrl_en_reg |->
      pad0_oe_n && pad1_oe_n && pad2_oe_n && pad3_oe_n)
      else $error("disabled block still drives pads");
   AST_FOUR: assert property (ctrl_en_reg && four_reg |-> pad0_oe_n && pad1_oe_n &&
      !pad3_oe_n && pad3_out == scl_reg)
      else $error("four-wire pad mapping wrong");
   AST_LAUNCH: assert property (launch && eng_reg == EN_IDLE |->
      ##[2:4] eng_reg == EN_START && !sda_reg && scl_reg)
      else $error("address write did not start the bus");
   AST_RDATA: assert property (reg_rd && reg_addr == TAC_OFS |=> reg_rdata == $past(tac_reg))
      else $error("address read back wrong");
   COV_TEN: cover property (launch && reg_wdata[TEN_BIT] ##[1:8] prod_reg == PR_A2);
   COV_HS: cover property (eng_reg == EN_RS2 ##1 eng_reg == EN_START && cur_reg[E_FAST]);
   COV_STALL: cover property (fill_s.valid && !fill_s.ready);
   COV_NACK: cover property (nack_evt);
endmodule

// [bench/iha_target_model.sv]
// iha_target_model: two-wire target that records bytes and answers acks
`timescale 1ns/1ps
module iha_target_model import iha_pkg::*; #(
   parameter logic [7:0] RD_BYTE = 8'hB4 // byte returned in read slots
) (
   input wire logic ref_clk, // sampling clock
   input wire logic scl, // clock line level
   input wire logic sda, // data line level
   input wire logic nack_en, // refuse every byte
   output logic sda_pull // pull data line low
);
   logic scl_q = 1'b1; // clock one sample ago
   logic sda_q = 1'b1; // data one sample ago
   logic [7:0] sh = 8'h00; // shift register, msb first
   int bitn = 0; // bit slot, 8 is the ack slot
   int starts = 0; // start conditions seen
   logic first = 1'b0; // next byte is the first after a start
   logic rd_arm = 1'b0; // address byte asked for a read
   logic rd_mode = 1'b0; // target drives data slots
   logic [7:0] rx_q[$]; // bytes received
   initial sda_pull = 1'b0;
   ////////////////////////////////////////////////////////////////
   // line watcher; no glitch filter, so the host must keep data still while clock is high
   always @(posedge ref_clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin // start or repeated start
         bitn <= 0;
         starts <= starts + 1;
         sda_pull <= 1'b0;
         first <= 1'b1;
         rd_arm <= 1'b0;
         rd_mode <= 1'b0;
      end else if (scl && !scl_q) begin // rising clock samples, msb first
         sh <= {sh[6:0], sda};
         bitn <= (bitn == 8) ? 0 : bitn + 1;
         if (bitn == 7) begin
            rx_q.push_back({sh[6:0], sda});
            rd_arm <= first && sda; // direction bit of the address byte
            first <= 1'b0;
         end
      end else if (!scl && scl_q) begin // ack slot; master code is never acked
         if (bitn == 8) begin
            sda_pull <= !nack_en && !rd_mode && (rx_q[$] !== MC_BYTE);
            rd_mode <= rd_mode || rd_arm;
         end else begin
            // read slots: msb of the byte is 1, so the line is free for STOP
            sda_pull <= rd_mode && !RD_BYTE[3'(7 - bitn)];
         end
      end
   end
endmodule

// [bench/iha_top_tb.sv]
// iha_top_tb: register and two-wire launch tests of the address launcher
`timescale 1ns/1ps
module iha_top_tb import iha_pkg::*;;
   logic ref_clk = 1'b0; // bench clock
   logic srst = 1'b1; // reset, high
   logic [7:0] reg_addr = 8'h00; // register address
   logic [31:0] reg_wdata = 32'h0; // write data
   logic reg_wr = 1'b0; // write strobe
   logic reg_rd = 1'b0; // read strobe
   logic [31:0] reg_rdata; // read data
   logic pad0_out, pad0_oe_n, pad1_out, pad1_oe_n; // two-wire pads
   logic pad2_out, pad2_oe_n, pad3_out, pad3_oe_n; // four-wire pads
   logic sda_pull; // target pulls data low
   logic nack_en = 1'b0; // target refuses bytes
   int bad_count = 0; // mismatches
   int n_compared = 0; // comparisons
   // open-drain wires with pull-ups
   wire scl = pad1_oe_n ? 1'b1 : pad1_out;
   wire sda = (pad0_oe_n ? 1'b1 : pad0_out) & ~sda_pull;
   always #2.5 ref_clk = ~ref_clk;
   iha_top dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad0_in(sda),
      .pad0_out(pad0_out), .pad0_oe_n(pad0_oe_n), .pad1_in(scl), .pad1_out(pad1_out),
      .pad1_oe_n(pad1_oe_n), .pad2_out(pad2_out), .pad2_oe_n(pad2_oe_n),
      .pad3_out(pad3_out), .pad3_oe_n(pad3_oe_n));
   localparam logic [7:0] RD_BYTE = 8'hB4; // byte the target returns on reads
   iha_target_model #(.RD_BYTE(RD_BYTE)) tgt (.ref_clk(ref_clk), .scl(scl), .sda(sda),
      .nack_en(nack_en),
      .sda_pull(sda_pull));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // launch, feed data bytes on demand, then compare what the target saw
   task automatic launch(input logic [31:0] w);
      logic [7:0] exp_q[$];
      logic [31:0] st;
      int n;
      int k;
      int s0;
      if (w[HS_BIT]) exp_q.push_back(MC_BYTE);
      if (w[TEN_BIT]) begin
         exp_q.push_back({TEN_PFX, w[10:9], w[0]});
         exp_q.push_back(w[8:1]);
      end else begin
         exp_q.push_back(w[7:0]);
      end
      n = w[BYTE_COUNT_ENABLE_BIT] ? int'(w[23:16]) : 0;
      for (k = 0; k < n; k++) exp_q.push_back(w[0] ? RD_BYTE : 8'hC0 + 8'(k));
      tgt.rx_q.delete();
      s0 = tgt.starts;
      wr(TAC_OFS, w);
      @(posedge ref_clk);
      #1 chk(pad0_oe_n, 1'b1);
      @(posedge ref_clk);
      #1 chk({pad0_oe_n, pad1_oe_n}, 2'b01);
      k = 0;
      for (int g = 0; g < 12000; g++) begin
         rd(STAT_OFS, st);
         if (st[0] === 1'b0) break;
         if (!w[0] && st[3] === 1'b0 && st[15:8] !== 8'h00) begin
            wr(DATA_OFS, {24'h0, 8'hC0 + 8'(k)});
            k++;
         end
      end
      chk(st[0], 1'b0);
      chk(tgt.starts - s0, w[HS_BIT] ? 2 : 1);
      chk(tgt.rx_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(tgt.rx_q[i], exp_q[i]);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      #1 chk({pad0_oe_n, pad1_oe_n, pad2_oe_n, pad3_oe_n}, 4'hF);
      rd(TAC_OFS, d);
      chk(d, TAC_RST);
      $display("reset test done");
   endtask
   // writable bits while disabled, no launch, unmapped read
   task automatic t_regs;
      logic [31:0] d;
      wr(TAC_OFS, 32'hFFFF_FFFF);
      rd(TAC_OFS, d);
      chk(d, TAC_MASK);
      chk(pad0_oe_n, 1'b1);
      rd(8'h40, d);
      chk(d, 32'h0);
      $display("register test done");
   endtask
   task automatic t_four;
      wr(CTRL_OFS, 32'h3);
      repeat (2) @(posedge ref_clk);
      #1 chk({pad0_oe_n, pad1_oe_n, pad2_oe_n, pad3_oe_n}, 4'hC);
      chk({pad0_out, pad1_out, pad2_out, pad3_out}, 4'h3);
      wr(CTRL_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 chk({pad0_oe_n, pad1_oe_n, pad2_oe_n, pad3_oe_n}, 4'hF);
      $display("four-wire test done");
   endtask
   task automatic t_launches;
      logic [31:0] d;
      wr(CTRL_OFS, 32'h1);
      launch(32'h0000_00A4);
      launch(32'h0000_82D6);
      launch(32'h0000_4052);
      launch(32'h0002_2050);
      launch(32'h0002_0050);
      // counted read: host acks the first byte, refuses the last
      launch(32'h0002_2053);
      rd(STAT_OFS, d);
      chk(d[2], 1'b1);
      rd(DATA_OFS, d);
      chk(d, {24'h00_0000, RD_BYTE});
      $display("launch test done");
   endtask
   // refused address byte sets the sticky flag; write one clears it
   task automatic t_nack;
      logic [31:0] d;
      nack_en = 1'b1;
      launch(32'h0000_0042);
      nack_en = 1'b0;
      rd(STAT_OFS, d);
      chk(d[ST_NACK_BIT], 1'b1);
      wr(STAT_OFS, 32'h2);
      rd(STAT_OFS, d);
      chk(d[ST_NACK_BIT], 1'b0);
      $display("refusal test done");
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset;
      t_regs;
      t_four;
      t_launches;
      t_nack;
      tally_and_finish;
   end
   // hang guard, well above the expected run of about 61000 cycles
   initial begin
      repeat (95000) @(posedge ref_clk);
      bad_count++;
      tally_and_finish;
   end
endmodule
